//--- ccd_line_timing.sv
// line timing sequencer for a three-channel linear ccd sensor
// assumes i_start and i_cfg come from logic on i_clk; cfg held stable
// while a line is in flight
`timescale 1ns/10ps
`include "ccd_map.svh"

module ccd_line_timing #(
    parameter int CELLS = `CCD_CELLS,
    parameter int CHANNELS = `CCD_CHANNELS
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // line request and settings
    input wire logic i_start,
    input wire ccd_pkg::ccd_cfg_s i_cfg,
    // sensor gates
    output ccd_pkg::ccd_gate_s o_gate,
    // readout status
    output logic o_busy,
    output logic o_pix_strobe,
    output ccd_pkg::ccd_cnt_t o_pix_index,
    output logic o_line_done
);

    localparam ccd_pkg::ccd_cnt_t LAST_CELL =
        ccd_pkg::ccd_cnt_t'(CELLS - 1);

    generate
        if (CELLS < 2 || CELLS >= (1 << `CCD_CNT_W)) begin : g_bad_cells
            $error("CELLS out of range for the pixel counter");
        end
        if (CHANNELS != `CCD_CHANNELS) begin : g_bad_ch
            $error("CHANNELS must match the gate struct width");
        end
    endgenerate

    typedef struct packed {
        ccd_pkg::ccd_state_e state;
        ccd_pkg::ccd_cnt_t cnt;
        ccd_pkg::ccd_cnt_t pix;
        // index of the cell just shifted; pix already points past it, except after the last cell
        ccd_pkg::ccd_cnt_t idx;
        logic tg1;
        logic tg2;
        logic [CHANNELS-1:0] drain;
        logic strobe;
        logic done;
    } ccd_lt_s;

    ccd_lt_s st_q;
    ccd_lt_s st_d;

    logic run;
    logic parked;
    logic shift_next;
    logic phase1;
    logic phase2;
    logic reset_gate;
    logic cnt_last;
    ccd_pkg::ccd_cnt_t cnt_lim;
    logic [CHANNELS-1:0] drain_fall;

    // clocks keep running except while parked for the transfer
    assign run = (st_q.state == ccd_pkg::CCD_IDLE) ||
                 (st_q.state == ccd_pkg::CCD_READ); // [RQ19] [RQ21]

    ccd_phase_gen u_phase (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_run(run),
        .i_half(i_cfg.half_cycles),
        .i_rst_w(i_cfg.rst_cycles),
        .o_phase1(phase1),
        .o_phase2(phase2),
        .o_reset_gate(reset_gate),
        .o_parked(parked),
        .o_shift_next(shift_next)
    );

    // the gates-on step times against tg_on_cycles, both gate-off steps against tg_gap_cycles
    always_comb begin
        case (st_q.state)
            ccd_pkg::CCD_TG_ON: begin
                cnt_lim = i_cfg.tg_on_cycles;
            end
            default: begin
                cnt_lim = i_cfg.tg_gap_cycles;
            end
        endcase
    end

    // a zero setting still gives one cycle per step
    assign cnt_last = (st_q.cnt + `CCD_CNT_ONE) >= cnt_lim;

    // per-channel drain release, on the same edge as the phase two fall
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_drain
            assign drain_fall[ch] = (st_q.state == ccd_pkg::CCD_READ) &&
                shift_next &&
                (st_q.pix == i_cfg.drain_end[ch]); // [RQ15] [RQ17]
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        st_d.strobe = 1'b0;
        st_d.done = 1'b0;
        case (st_q.state)
            ccd_pkg::CCD_IDLE: begin
                // integration: photodiodes isolated from the registers
                st_d.tg1 = `CCD_GATE_OFF; // [RQ1]
                st_d.tg2 = `CCD_GATE_OFF; // [RQ1]
                if (i_start) begin
                    st_d.state = ccd_pkg::CCD_PARK;
                end
            end
            ccd_pkg::CCD_PARK: begin
                // no gate moves until the phases are held
                if (parked) begin // [RQ2]
                    st_d.tg1 = 1'b1; // [RQ3]
                    st_d.tg2 = 1'b1; // [RQ3]
                    st_d.cnt = `CCD_CNT_ZERO;
                    st_d.state = ccd_pkg::CCD_TG_ON;
                end
            end
            ccd_pkg::CCD_TG_ON: begin
                if (cnt_last) begin
                    st_d.tg1 = `CCD_GATE_OFF; // [RQ4]
                    // drain rises on the first gate fall; edge hidden in
                    // the transfer so no artefact reaches the output
                    st_d.drain = {CHANNELS{1'b1}}; // [RQ13] [RQ16] [RQ12]
                    st_d.cnt = `CCD_CNT_ZERO;
                    st_d.state = ccd_pkg::CCD_TG1_OFF;
                end else begin
                    st_d.cnt = st_q.cnt + `CCD_CNT_ONE;
                end
            end
            ccd_pkg::CCD_TG1_OFF: begin
                if (cnt_last) begin
                    st_d.tg2 = `CCD_GATE_OFF; // [RQ5]
                    st_d.cnt = `CCD_CNT_ZERO;
                    st_d.state = ccd_pkg::CCD_TG2_OFF;
                end else begin
                    st_d.cnt = st_q.cnt + `CCD_CNT_ONE;
                end
            end
            ccd_pkg::CCD_TG2_OFF: begin
                if (cnt_last) begin
                    st_d.pix = `CCD_CNT_ZERO;
                    st_d.cnt = `CCD_CNT_ZERO;
                    st_d.state = ccd_pkg::CCD_READ; // [RQ6]
                end else begin
                    st_d.cnt = st_q.cnt + `CCD_CNT_ONE;
                end
            end
            ccd_pkg::CCD_READ: begin
                // exposure ends at next line's first gate fall, so the
                // drain release point sets it per channel
                st_d.drain = st_q.drain & ~drain_fall; // [RQ14]
                if (shift_next) begin // [RQ8] [RQ9]
                    st_d.strobe = 1'b1;
                    st_d.idx = st_q.pix;
                    if (st_q.pix == LAST_CELL) begin // [RQ11]
                        st_d.done = 1'b1;
                        st_d.state = ccd_pkg::CCD_IDLE;
                    end else begin
                        st_d.pix = st_q.pix + `CCD_CNT_ONE;
                    end
                end
            end
            default: begin
                st_d.tg1 = `CCD_GATE_OFF;
                st_d.tg2 = `CCD_GATE_OFF;
                st_d.state = ccd_pkg::CCD_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q.state <= ccd_pkg::CCD_IDLE;
            st_q.cnt <= `CCD_CNT_ZERO;
            st_q.pix <= `CCD_CNT_ZERO;
            st_q.idx <= `CCD_CNT_ZERO;
            st_q.tg1 <= `CCD_GATE_OFF; // [RQ21]
            st_q.tg2 <= `CCD_GATE_OFF; // [RQ21]
            st_q.drain <= `CCD_DRAIN_RST; // [RQ21]
            st_q.strobe <= 1'b0;
            st_q.done <= 1'b0;
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    // shared phases feed every channel register
    assign o_gate.phase1 = phase1; // [RQ8]
    assign o_gate.phase2 = phase2; // [RQ8]
    assign o_gate.transfer_gate_first = st_q.tg1;
    assign o_gate.transfer_gate_second = st_q.tg2;
    assign o_gate.exposure_drain = st_q.drain;
    assign o_gate.output_reset_gate_pin = reset_gate;
    assign o_busy = (st_q.state != ccd_pkg::CCD_IDLE);
    assign o_pix_strobe = st_q.strobe;
    assign o_pix_index = st_q.idx;
    assign o_line_done = st_q.done;

endmodule

//--- ccd_line_timing_fix.sv
// holds no module; both design modules live in files of their own

//--- ccd_line_timing_tb.sv
// self-checking bench for the line timing generator, short lines
// assumes the checker is bound and the sensor model sits on o_gate
`timescale 1ns/10ps
module ccd_line_timing_tb;
    localparam int CELLS = 8;
    // phase one high, every gate, drain and reset pulse off
    localparam ccd_pkg::ccd_gate_s G_RST = 8'h80;
    logic i_clk, i_rstn, i_ce, i_start, o_busy, o_pix_strobe, o_line_done;
    ccd_pkg::ccd_cfg_s i_cfg;
    ccd_pkg::ccd_gate_s o_gate, g_q;
    ccd_pkg::ccd_cnt_t o_pix_index, pix_cnt, line_cnt, nxt;
    logic [2:0][15:0] fall_at;
    int err_total, num_checks, cyc, n_str, n_rst, n_tog, t_on, t_f1, t_f2;
    int lines;
    ccd_line_timing #(.CELLS(CELLS)) DUT (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_start(i_start),
        .i_cfg(i_cfg), .o_gate(o_gate), .o_busy(o_busy),
        .o_pix_strobe(o_pix_strobe), .o_pix_index(o_pix_index),
        .o_line_done(o_line_done));
    ccd_sensor_model u_sensor (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_gate(o_gate), .o_pix_cnt(pix_cnt), .o_line_cnt(line_cnt));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_gate(string nm, ccd_pkg::ccd_gate_s e,
        ccd_pkg::ccd_gate_s g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // edge watcher on settled outputs
    always @(negedge i_clk) begin
        if (o_pix_strobe) begin
            chk("pix_index", nxt, o_pix_index);
            nxt = (nxt == 16'(CELLS - 1)) ? 16'h0000 : nxt + 16'h0001;
            n_str++;
        end
        for (int k = 0; k < 3; k++) begin
            if (g_q.exposure_drain[k] && !o_gate.exposure_drain[k]) begin
                fall_at[k] = o_pix_index;
            end
        end
        n_rst += int'(o_gate.output_reset_gate_pin &&
            !g_q.output_reset_gate_pin);
        n_tog += int'(o_gate.phase1 != g_q.phase1);
        if (o_gate.transfer_gate_first && !g_q.transfer_gate_first) begin
            t_on = cyc;
        end
        if (!o_gate.transfer_gate_first && g_q.transfer_gate_first) begin
            t_f1 = cyc;
        end
        if (!o_gate.transfer_gate_second &&
            g_q.transfer_gate_second) begin
            t_f2 = cyc;
        end
        g_q = o_gate;
        cyc++;
    end
    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask
    task automatic wait_done;
        int i;
        i = 0;
        while (o_line_done !== 1'b1 && i < 2000) begin
            tick();
            i++;
        end
        // a line that never ends counts as a mismatch here
        chk("line_done", 16'h0001, {15'h0, o_line_done});
    endtask
    task automatic do_reset;
        i_rstn = 1'b0;
        nxt = 16'h0000;
        lines = 0;
        repeat (12) tick();
        chk_gate("gate_rst", G_RST, o_gate);
        chk("busy_rst", 16'h0000, {15'h0, o_busy});
        i_rstn = 1'b1;
        n_tog = 0;
        repeat (20) tick();
        chk("phase_runs", 16'h0001, {15'h0, n_tog >= 3});
    endtask
    // one line, with a second request mid-line that must be ignored
    task automatic run_line;
        n_str = 0;
        n_rst = 0;
        fall_at = '1;
        i_start = 1'b1;
        tick();
        i_start = 1'b0;
        chk("busy", 16'h0001, {15'h0, o_busy});
        repeat (5) tick();
        i_start = 1'b1;
        tick();
        i_start = 1'b0;
        wait_done();
        chk("busy_end", 16'h0000, {15'h0, o_busy});
        tick();
        lines++;
        chk("tg_on", 16'h0004, 16'(t_f1 - t_on));
        chk("tg_gap", 16'h0002, 16'(t_f2 - t_f1));
        chk("strobes", 16'(CELLS), 16'(n_str));
        chk("drain0", 16'h0000, fall_at[0]);
        chk("drain1", 16'h0005, fall_at[1]);
        chk("drain2", 16'hffff, fall_at[2]);
        chk("rst_pulses", 16'h0001, {15'h0, n_rst >= CELLS});
        chk("sensor_pix", 16'(CELLS), pix_cnt);
        chk("sensor_lines", 16'(lines), line_cnt);
    endtask
    task automatic t_freeze;
        ccd_pkg::ccd_gate_s g;
        i_ce = 1'b0;
        i_start = 1'b1;
        g = o_gate;
        repeat (10) tick();
        chk_gate("frozen", g, o_gate);
        chk("busy_frozen", 16'h0000, {15'h0, o_busy});
        i_start = 1'b0;
        i_ce = 1'b1;
    endtask
    // held request: next line taken right after done
    task automatic t_b2b;
        n_str = 0;
        i_start = 1'b1;
        tick();
        wait_done();
        chk("gap_idle", 16'h0000, {15'h0, o_busy});
        tick();
        chk("retaken", 16'h0001, {15'h0, o_busy});
        i_start = 1'b0;
        wait_done();
        tick();
        chk("strobes2", 16'(2 * CELLS), 16'(n_str));
    endtask
    task automatic t_abort;
        int i;
        i = 0;
        i_start = 1'b1;
        tick();
        i_start = 1'b0;
        while (o_gate.transfer_gate_first !== 1'b1 && i < 200) begin
            tick();
            i++;
        end
        do_reset();
    endtask
    initial begin
        i_rstn = 1'b0;
        i_ce = 1'b1;
        i_start = 1'b0;
        i_cfg = {16'h0003, 16'h0001, 16'h0004, 16'h0002,
            16'h0008, 16'h0005, 16'h0000};
        err_total = 0;
        num_checks = 0;
        cyc = 0;
        g_q = G_RST;
        do_reset();
        run_line();
        t_freeze();
        t_b2b();
        t_abort();
        run_line();
        close_out();
    end
    // whole run is well under a thousand cycles
    initial begin
        #100000;
        err_total++;
        close_out();
    end
endmodule

//--- ccd_lt_checker.sv
// port assertions for the line timing generator
// assumes one clock domain; bound into every ccd_line_timing
`timescale 1ns/10ps
module ccd_lt_checker #(
    parameter int CELLS = 8022
) (
    // clock, reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // inputs
    input wire logic i_ce,
    input wire logic i_start,
    // outputs
    input wire ccd_pkg::ccd_gate_s o_gate,
    input wire logic o_busy,
    input wire logic o_pix_strobe,
    input wire ccd_pkg::ccd_cnt_t o_pix_index,
    input wire logic o_line_done
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire tg1 = o_gate.transfer_gate_first;
    wire tg2 = o_gate.transfer_gate_second;
    wire [2:0] dr = o_gate.exposure_drain;
    a_phase_compl: assert property (
        o_gate.phase1 != o_gate.phase2)
        else $error("phases not complementary");
    a_idle_gates_off: assert property (!o_busy |-> !tg1 && !tg2)
        else $error("transfer gate on while idle");
    a_tg_park: assert property ((tg1 || tg2) |->
        o_gate.phase1 && !o_gate.phase2) else $error("phases not parked");
    a_tg_rise_pair: assert property ($rose(tg1) |-> $rose(tg2))
        else $error("transfer gates not raised together");
    a_tg1_in_tg2: assert property (tg1 |-> tg2)
        else $error("first gate on without second");
    a_tg2_late: assert property ($fell(tg2) |-> !tg1 && !$past(tg1))
        else $error("second gate fell too early");
    a_drain_rise: assert property (
        (dr & ~$past(dr)) != 3'h0 |-> $fell(tg1))
        else $error("drain rose off the gate fall");
    a_drain_all: assert property ($fell(tg1) |-> dr == 3'h7)
        else $error("drains not all raised");
    a_drain_fall: assert property ((~dr & $past(dr)) != 3'h0 |->
        $fell(o_gate.phase2)) else $error("drain fall off phase edge");
    a_strobe_fall: assert property (o_pix_strobe |->
        $fell(o_gate.phase2)) else $error("strobe off phase two fall");
    a_done_last: assert property (o_line_done |-> o_pix_strobe &&
        o_pix_index == 16'(CELLS - 1)) else $error("done not on last cell");
    a_reset_in_p2: assert property (o_gate.output_reset_gate_pin |->
        o_gate.phase2) else $error("reset gate outside phase two");
    a_start_taken: assert property (
        i_ce && i_start && !o_busy |=> o_busy)
        else $error("line request not taken");
    c_line: cover property (o_line_done);
    c_tg2_off: cover property ($fell(tg2));
    c_drain_mid: cover property ($fell(dr[1]));
endmodule
bind ccd_line_timing ccd_lt_checker #(.CELLS(CELLS)) u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_start(i_start),
    .o_gate(o_gate), .o_busy(o_busy), .o_pix_strobe(o_pix_strobe),
    .o_pix_index(o_pix_index), .o_line_done(o_line_done));

//--- ccd_map.svh
// named constants for the trilinear line timing generator
// assumes inclusion by bare name from the package and design modules
//
// What this block does
// (RQ1) both transfer gates stay off for the whole integration period
// (RQ2) at line end stop clocking with phase one high, phase two low
// (RQ3) with phases parked, turn both transfer gates on together
// (RQ4) then turn the first transfer gate off, second stays on
// (RQ5) only after the first is off, turn the second gate off
// (RQ6) after second gate off, resume complementary clocking for readout
// (RQ7) readout phases are a complementary pair, one high, one low
// (RQ8) one phase pair drives all three channel registers together
// (RQ9) pixel charge reaches all outputs on the phase two falling edge
// (RQ10) pulse the output reset gate once before each pixel output
// (RQ11) pixel counter spans 8022 cells per line
// (RQ12) drain gate high with first gate off diverts photocurrent
// (RQ13) raise drain gate as first gate turns off, lower during scan
// (RQ14) exposure is drain fall to first gate fall at line end
// (RQ15) each colour channel has its own drain gate and setting
// (RQ16) drain rising edge placed on the first transfer gate fall
// (RQ17) drain falling edge aligned with the phase clock edges
// (RQ18) both phases come from one flop so they stay complements
// (RQ19) phase clocks keep running between lines, no abrupt stops
// (RQ20) pulse widths, gaps, phase rate and exposure are programmable
// (RQ21) after reset gates off, drains low, clocking before transfer
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

`define CCD_CELLS 8022
`define CCD_CHANNELS 3
`define CCD_CNT_W 16
`define CCD_CNT_ONE 16'h0001
`define CCD_CNT_ZERO 16'h0000
`define CCD_PHASE1_RST 1'b1
`define CCD_GATE_OFF 1'b0
`define CCD_DRAIN_RST 3'h0

`endif

//--- ccd_phase_gen.sv
// two-phase register clock and output reset gate generator
// assumes one clock domain; i_run comes from the line sequencer
`timescale 1ns/10ps
`include "ccd_map.svh"

module ccd_phase_gen (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // control
    input wire logic i_run,
    input wire ccd_pkg::ccd_cnt_t i_half,
    input wire ccd_pkg::ccd_cnt_t i_rst_w,
    // phase outputs
    output logic o_phase1,
    output logic o_phase2,
    output logic o_reset_gate,
    output logic o_parked,
    output logic o_shift_next
);

    typedef struct packed {
        logic ph;
        logic stopped;
        logic rg;
        ccd_pkg::ccd_cnt_t cnt;
    } ccd_pg_s;

    ccd_pg_s st_q;
    ccd_pg_s st_d;
    logic last;
    logic adv;

    assign last = (st_q.cnt + `CCD_CNT_ONE) >= i_half;
    // a phase-two-high half always runs out, so parking lands on phase one
    assign adv = i_run || !st_q.ph;
    assign o_shift_next = i_ce && adv && !st_q.ph && last; // [RQ9]

    always_comb begin
        st_d = st_q;
        if (adv) begin
            st_d.stopped = 1'b0;
            if (last) begin
                st_d.cnt = `CCD_CNT_ZERO;
                st_d.ph = ~st_q.ph; // [RQ7]
            end else begin
                st_d.cnt = st_q.cnt + `CCD_CNT_ONE;
            end
        end else begin
            // held with phase one high and phase two low
            st_d.cnt = `CCD_CNT_ZERO;
            st_d.stopped = 1'b1; // [RQ2]
        end
        // reset pulse at the head of the phase-two-high half
        st_d.rg = !st_d.ph && (st_d.cnt < i_rst_w) && adv; // [RQ10]
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q.ph <= `CCD_PHASE1_RST;
            st_q.stopped <= 1'b0;
            st_q.rg <= 1'b0;
            st_q.cnt <= `CCD_CNT_ZERO;
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    // both phases from one flop keeps them exact complements
    assign o_phase1 = st_q.ph; // [RQ18]
    assign o_phase2 = ~st_q.ph; // [RQ18]
    assign o_reset_gate = st_q.rg;
    assign o_parked = st_q.stopped;

endmodule

//--- ccd_pkg.sv
// types shared by the line timing generator modules
// assumes ccd_map.svh is on the include path
`include "ccd_map.svh"

package ccd_pkg;

    typedef logic [`CCD_CNT_W-1:0] ccd_cnt_t;

    // timing settings, all in system clock cycles except drain_end
    typedef struct packed {
        ccd_cnt_t half_cycles;
        ccd_cnt_t rst_cycles;
        ccd_cnt_t tg_on_cycles;
        ccd_cnt_t tg_gap_cycles;
        // cell index at which each channel's drain gate falls
        logic [`CCD_CHANNELS-1:0][`CCD_CNT_W-1:0] drain_end;
    } ccd_cfg_s;

    typedef struct packed {
        logic phase1;
        logic phase2;
        logic transfer_gate_first;
        logic transfer_gate_second;
        logic [`CCD_CHANNELS-1:0] exposure_drain;
        logic output_reset_gate_pin;
    } ccd_gate_s;

    typedef enum logic [2:0] {
        CCD_IDLE,
        CCD_PARK,
        CCD_TG_ON,
        CCD_TG1_OFF,
        CCD_TG2_OFF,
        CCD_READ
    } ccd_state_e;

endpackage

//--- ccd_sensor_model.sv
// sensor side model: counts line transfers and delivered pixels
// assumes gates come straight from the timing block
`timescale 1ns/10ps
module ccd_sensor_model (
    // clock, reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // gate inputs
    input wire ccd_pkg::ccd_gate_s i_gate,
    // charge flow seen
    output ccd_pkg::ccd_cnt_t o_pix_cnt,
    output ccd_pkg::ccd_cnt_t o_line_cnt
);
    logic p2_q, tg1_q;
    // samples settled levels, so it sees every edge of the flops
    always @(negedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            p2_q <= 1'b0;
            tg1_q <= 1'b0;
            o_pix_cnt <= 16'h0000;
            o_line_cnt <= 16'h0000;
        end else begin
            p2_q <= i_gate.phase2;
            tg1_q <= i_gate.transfer_gate_first;
            if (tg1_q && !i_gate.transfer_gate_first &&
                i_gate.transfer_gate_second) begin
                o_line_cnt <= o_line_cnt + 16'h0001;
                o_pix_cnt <= 16'h0000;
            end else if (p2_q && !i_gate.phase2) begin
                o_pix_cnt <= o_pix_cnt + 16'h0001;
            end
        end
    end
endmodule
